// ==== hdl/ldcfg_pkg.sv ====
// Constants and types for the per-unit configuration register bank
// -----------------------------------------------------------------
// How it works
// R1: Bit 0 of index 0x30 activates the unit chosen by the selector.
// R2: Software writes zeros to activation bits 7:1; they are reserved.
// R3: Activation and base address bytes reset to 0x00 on every reset kind.
// R4: Indexes 0x31 to 0x5F ignore writes and read zero.
// R5: Index 0x60 holds base bits 15:8, index 0x61 bits 7:0.
// R6: A second base address sits at 0x62 high and 0x63 low.
// R7: Base indexes a unit does not use ignore writes, read zero.
// R8: Every unit has a primary interrupt select at 0x70.
// R9: Only the keyboard unit has 0x72, reset 0x00; others read zero.
// R10: Selected interrupts default to active-high edge signalling.
// R11: Indexes 0x71, 0x73, 0x76-0xA8, 0xA9-0xDF ignore writes, read zero.
// R12: DMA select 0x74 only for floppy and parallel units; 0x75 reads zero.
// R13: Unit 0 interrupt resets 0x06; DMA resets 0x02 unit 0, 0x04 units 3, 5.
// R14: Activation and power-control bits are linked; either set means on.
// R15: Banks chosen by selector 0x07, reachable only in configuration state.
// R16: Index 0xFF ignores writes and reads zero.
// -----------------------------------------------------------------
package ldcfg_pkg;

	localparam int UNIT_COUNT = 12;
	localparam int UNIT_W = 4;

	localparam logic [7:0] IDX_UNIT_SEL = 8'h07;
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_BASE_HI = 8'h60;
	localparam logic [7:0] IDX_BASE_LO = 8'h61;
	localparam logic [7:0] IDX_BASE2_HI = 8'h62;
	localparam logic [7:0] IDX_BASE2_LO = 8'h63;
	localparam logic [7:0] IDX_IRQ_PRI = 8'h70;
	localparam logic [7:0] IDX_IRQ_SEC = 8'h72;
	localparam logic [7:0] IDX_DMA_SEL = 8'h74;
	localparam logic [7:0] IDX_LAST = 8'hFF;

	localparam int ACT_BIT = 0;
	localparam logic [7:0] ACT_RSV_MASK = 8'hFE;

	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_IRQ_UNIT0 = 8'h06;
	localparam logic [7:0] RST_DMA_UNIT0 = 8'h02;
	localparam logic [7:0] RST_DMA_UNIT35 = 8'h04;

	localparam logic [3:0] UNIT_FLOPPY = 4'h0;
	localparam logic [3:0] UNIT_PARALLEL = 4'h3;
	localparam logic [3:0] UNIT_SERIAL2 = 4'h5;
	localparam logic [3:0] UNIT_KEYBOARD = 4'h7;

	// One host access through the index/data pair, already decoded
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} cfg_req_t;

	// Per-unit settings as seen by the unit's own logic
	typedef struct packed {
		logic on;
		logic [15:0] base;
		logic [15:0] base2;
		logic [7:0] irq_pri;
		logic [7:0] irq_sec;
		logic [7:0] dma;
	} unit_cfg_t;

endpackage

// ==== hdl/logical_device_config_bank.sv ====
// Per-unit configuration register bank behind the index/data port pair
`timescale 1ns/1ps
module logical_device_config_bank import ldcfg_pkg::*; #(
	parameter int UNITS = UNIT_COUNT,
	parameter logic [UNIT_COUNT-1:0] HAS_BASE = 12'hE39,
	parameter logic [UNIT_COUNT-1:0] HAS_BASE2 = 12'h000
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic soft_reset,
	input wire logic config_state,
	input wire cfg_req_t req,
	input wire logic [UNIT_COUNT-1:0] power_ctl_set,
	input wire logic [UNIT_COUNT-1:0] power_ctl_clr,
	output logic [7:0] rdata,
	output logic [UNIT_COUNT-1:0] power_ctl,
	output unit_cfg_t [UNIT_COUNT-1:0] unit_cfg
);

	// -----------------------------------------------------------------
	// Storage
	// -----------------------------------------------------------------
	logic [UNIT_W-1:0] sel_q;
	logic [UNIT_COUNT-1:0] act_q;
	logic [7:0] bhi_q [UNIT_COUNT];
	logic [7:0] blo_q [UNIT_COUNT];
	logic [7:0] b2hi_q [UNIT_COUNT];
	logic [7:0] b2lo_q [UNIT_COUNT];
	logic [7:0] irq_q [UNIT_COUNT];
	logic [7:0] irq2_q;
	logic [7:0] dma_q [UNIT_COUNT];
	logic wr_ok;
	logic rd_ok;
	logic [7:0] rdata_d;
	logic sel_ok;

	// Bank only reachable while in the configuration state
	assign wr_ok = req.wr && config_state; // R15
	assign rd_ok = req.rd && config_state; // R15

	// Selector codes past the last unit reach no bank, so read zero
	assign sel_ok = sel_q < UNIT_COUNT;

	function automatic logic [7:0] irq_rst(input int u);
		return (u == 0) ? RST_IRQ_UNIT0 : RST_ZERO; // R13
	endfunction

	function automatic logic [7:0] dma_rst(input int u);
		if (u == 0) begin
			return RST_DMA_UNIT0; // R13
		end else if (u == UNIT_PARALLEL || u == UNIT_SERIAL2) begin
			return RST_DMA_UNIT35; // R13
		end
		return RST_ZERO;
	endfunction

	function automatic logic has_dma(input logic [UNIT_W-1:0] u);
		return (u == UNIT_FLOPPY) || (u == UNIT_PARALLEL); // R12
	endfunction

	// -----------------------------------------------------------------
	// Unit selector
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_q <= '0;
		end else if (soft_reset) begin
			sel_q <= '0;
		end else if (wr_ok && req.index == IDX_UNIT_SEL) begin
			sel_q <= req.wdata[UNIT_W-1:0]; // R15
		end
	end

	// -----------------------------------------------------------------
	// Activation, linked to the power-control bit
	// -----------------------------------------------------------------
	// A register write wins over a same-cycle power-control request
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			act_q <= '0; // R3
		end else if (soft_reset) begin
			act_q <= '0; // R3
		end else begin
			for (int u = 0; u < UNIT_COUNT; u++) begin
				if (wr_ok && req.index == IDX_ACTIVATE &&
						sel_q == u[UNIT_W-1:0]) begin
					act_q[u] <= req.wdata[ACT_BIT]; // R1 R2
				end else if (power_ctl_set[u]) begin
					act_q[u] <= 1'b1; // R14
				end else if (power_ctl_clr[u]) begin
					act_q[u] <= 1'b0; // R14
				end
			end
		end
	end

	// One shared flop keeps both bits equal by construction
	assign power_ctl = act_q; // R14

	// -----------------------------------------------------------------
	// Base addresses
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int u = 0; u < UNIT_COUNT; u++) begin
				bhi_q[u] <= RST_ZERO; // R3
				blo_q[u] <= RST_ZERO; // R3
				b2hi_q[u] <= RST_ZERO;
				b2lo_q[u] <= RST_ZERO;
			end
		end else if (soft_reset) begin
			for (int u = 0; u < UNIT_COUNT; u++) begin
				bhi_q[u] <= RST_ZERO; // R3
				blo_q[u] <= RST_ZERO; // R3
				b2hi_q[u] <= RST_ZERO;
				b2lo_q[u] <= RST_ZERO;
			end
		end else if (wr_ok && sel_ok && HAS_BASE[sel_q]) begin // R7
			if (req.index == IDX_BASE_HI) begin
				bhi_q[sel_q] <= req.wdata; // R5
			end else if (req.index == IDX_BASE_LO) begin
				blo_q[sel_q] <= req.wdata; // R5
			end else if (HAS_BASE2[sel_q] && req.index == IDX_BASE2_HI) begin
				b2hi_q[sel_q] <= req.wdata; // R6
			end else if (HAS_BASE2[sel_q] && req.index == IDX_BASE2_LO) begin
				b2lo_q[sel_q] <= req.wdata; // R6
			end
		end
	end

	// -----------------------------------------------------------------
	// Interrupt and DMA selects
	// -----------------------------------------------------------------
	// Edge-high signalling is the reset polarity of every selected line
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int u = 0; u < UNIT_COUNT; u++) begin
				irq_q[u] <= irq_rst(u); // R13 R10
			end
			irq2_q <= RST_ZERO; // R9
		end else if (soft_reset) begin
			for (int u = 0; u < UNIT_COUNT; u++) begin
				irq_q[u] <= irq_rst(u); // R13 R10
			end
			irq2_q <= RST_ZERO; // R9
		end else if (wr_ok) begin
			if (req.index == IDX_IRQ_PRI && sel_ok) begin
				irq_q[sel_q] <= req.wdata; // R8
			end else if (req.index == IDX_IRQ_SEC &&
					sel_q == UNIT_KEYBOARD) begin
				irq2_q <= req.wdata; // R9
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int u = 0; u < UNIT_COUNT; u++) begin
				dma_q[u] <= dma_rst(u); // R13
			end
		end else if (soft_reset) begin
			for (int u = 0; u < UNIT_COUNT; u++) begin
				dma_q[u] <= dma_rst(u); // R13
			end
		end else if (wr_ok && req.index == IDX_DMA_SEL && has_dma(sel_q)) begin
			dma_q[sel_q] <= req.wdata; // R12
		end
	end

	// -----------------------------------------------------------------
	// Read path; every unlisted index reads zero
	// -----------------------------------------------------------------
	always_comb begin
		rdata_d = RST_ZERO; // R4 R11 R16
		if (req.index == IDX_UNIT_SEL) begin
			rdata_d = {{(8-UNIT_W){1'b0}}, sel_q};
		end else if (!sel_ok) begin
			rdata_d = RST_ZERO;
		end else if (req.index == IDX_ACTIVATE) begin
			rdata_d = {7'h00, act_q[sel_q]}; // R1
		end else if (req.index == IDX_BASE_HI && HAS_BASE[sel_q]) begin
			rdata_d = bhi_q[sel_q]; // R5 R7
		end else if (req.index == IDX_BASE_LO && HAS_BASE[sel_q]) begin
			rdata_d = blo_q[sel_q]; // R5 R7
		end else if (req.index == IDX_BASE2_HI && HAS_BASE[sel_q] &&
				HAS_BASE2[sel_q]) begin
			rdata_d = b2hi_q[sel_q]; // R6 R7
		end else if (req.index == IDX_BASE2_LO && HAS_BASE[sel_q] &&
				HAS_BASE2[sel_q]) begin
			rdata_d = b2lo_q[sel_q]; // R6 R7
		end else if (req.index == IDX_IRQ_PRI) begin
			rdata_d = irq_q[sel_q]; // R8
		end else if (req.index == IDX_IRQ_SEC && sel_q == UNIT_KEYBOARD) begin
			rdata_d = irq2_q; // R9
		end else if (req.index == IDX_DMA_SEL && has_dma(sel_q)) begin
			rdata_d = dma_q[sel_q]; // R12
		end
	end

	// Read data held until the next read
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= RST_ZERO;
		end else if (rd_ok) begin
			rdata <= rdata_d;
		end
	end

	// -----------------------------------------------------------------
	// Per-unit outputs
	// -----------------------------------------------------------------
	always_comb begin
		for (int u = 0; u < UNIT_COUNT; u++) begin
			unit_cfg[u].on = act_q[u]; // R14
			unit_cfg[u].base = {bhi_q[u], blo_q[u]};
			unit_cfg[u].base2 = {b2hi_q[u], b2lo_q[u]};
			unit_cfg[u].irq_pri = irq_q[u];
			unit_cfg[u].irq_sec = (u == UNIT_KEYBOARD) ? irq2_q : RST_ZERO;
			unit_cfg[u].dma = dma_q[u];
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	sequence s_act_write;
		wr_ok && req.index == IDX_ACTIVATE;
	endsequence

	AST_ACT_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
		(s_act_write and !soft_reset) |=>
		act_q[$past(sel_q)] == $past(req.wdata[0]))
		else $error("activation bit not written");

	AST_RSV_READ: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
		rd_ok && req.index > IDX_ACTIVATE && req.index < IDX_BASE_HI
		|=> rdata == 8'h00)
		else $error("reserved index read not zero");

	AST_UNUSED_READ: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
		rd_ok && (req.index == 8'h71 || req.index == 8'h73 ||
		(req.index >= 8'h76 && req.index <= 8'hDF)) |=> rdata == 8'h00)
		else $error("unimplemented index read not zero");

	AST_LAST_READ: assert property (@(posedge sys_clk) disable iff (!rst_b) // R16
		rd_ok && req.index == IDX_LAST |=> rdata == 8'h00)
		else $error("index FF read not zero");

	AST_SOFT_RST: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
		soft_reset |=> act_q == '0 && bhi_q[0] == 8'h00 && blo_q[0] == 8'h00)
		else $error("soft reset did not clear");

	AST_SOFT_DFLT: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
		soft_reset |=> irq_q[0] == 8'h06 && dma_q[0] == 8'h02 &&
		dma_q[3] == 8'h04 && dma_q[5] == 8'h04)
		else $error("unit defaults wrong after soft reset");

	AST_IRQ2_ONLY_KBD: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
		wr_ok && req.index == IDX_IRQ_SEC && sel_q != UNIT_KEYBOARD
		&& !soft_reset |=> $stable(irq2_q))
		else $error("secondary interrupt written by wrong unit");

	AST_DMA_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
		rd_ok && req.index == IDX_DMA_SEL && sel_q != UNIT_FLOPPY &&
		sel_q != UNIT_PARALLEL |=> rdata == 8'h00)
		else $error("DMA select visible on wrong unit");

	AST_LOCKED: assert property (@(posedge sys_clk) disable iff (!rst_b) // R15
		req.wr && !config_state && !soft_reset |=> $stable(sel_q) &&
		irq_q[$past(sel_q)] == $past(irq_q[sel_q]))
		else $error("write accepted outside configuration state");

	AST_POWER_LINK: assert property (@(posedge sys_clk) disable iff (!rst_b) // R14
		power_ctl_set[4] && !soft_reset && !(wr_ok &&
		req.index == IDX_ACTIVATE) |=> power_ctl[4] && unit_cfg[4].on)
		else $error("power control not linked to activation");

endmodule

// ==== test/logical_device_config_bank_tb.sv ====
// Self-checking bench for the per-unit configuration register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
	failures++; $display("wrong value at %0t: got %h want %h", $time, \
	got, exp); end end
module logical_device_config_bank_tb import ldcfg_pkg::*;;
	// ----------------------------------------
	// Signals and design
	// ----------------------------------------
	logic sys_clk;
	logic rst_b;
	logic soft_reset;
	logic config_state;
	cfg_req_t req;
	logic [UNIT_COUNT-1:0] power_ctl_set;
	logic [UNIT_COUNT-1:0] power_ctl_clr;
	logic [UNIT_COUNT-1:0] power_ctl;
	logic [7:0] rdata;
	unit_cfg_t [UNIT_COUNT-1:0] unit_cfg;
	int failures;
	int n_compared;
	// Unbacked indexes, both ends of every span
	localparam logic [7:0] RSV [16] = '{8'h31, 8'h37, 8'h38, 8'h3F,
		8'h40, 8'h5F, 8'h64, 8'h6F, 8'h71, 8'h73, 8'h75, 8'h76, 8'hA8,
		8'hA9, 8'hDF, 8'hFF};

	// Unit 4 given a second base so both pair halves are reachable
	logical_device_config_bank #(.HAS_BASE2(12'h010)) uut (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.soft_reset(soft_reset),
		.config_state(config_state),
		.req(req),
		.power_ctl_set(power_ctl_set),
		.power_ctl_clr(power_ctl_clr),
		.rdata(rdata),
		.power_ctl(power_ctl),
		.unit_cfg(unit_cfg)
	);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Access tasks, entered at a falling edge
	// ----------------------------------------
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		req.index = i;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge sys_clk);
		req.wr = 1'b0;
		// Idle edge so a following call never re-raises the strobe at once
		@(negedge sys_clk);
	endtask

	task automatic rdc(input logic [7:0] i, input logic [7:0] exp);
		req.index = i;
		req.rd = 1'b1;
		@(negedge sys_clk);
		req.rd = 1'b0;
		`CHK(rdata, exp)
		@(negedge sys_clk);
	endtask

	task automatic sel(input logic [3:0] u);
		wr(IDX_UNIT_SEL, {4'h0, u});
	endtask

	task automatic endt(input string s);
		$display("test %s done", s);
	endtask

	task automatic close_out();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Hang guard; the run needs far fewer cycles
	initial begin
		#200000;
		failures++;
		close_out();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		soft_reset = 1'b0;
		config_state = 1'b1;
		req = '0;
		power_ctl_set = '0;
		power_ctl_clr = '0;
		failures = 0;
		n_compared = 0;
		repeat (5) @(negedge sys_clk);
		rst_b = 1'b1;
		`CHK(power_ctl, 12'h000);
		`CHK(unit_cfg[5].dma, 8'h04);
		`CHK(unit_cfg[3].dma, 8'h04);
		sel(4'h0);
		rdc(IDX_IRQ_PRI, 8'h06);
		rdc(IDX_DMA_SEL, 8'h02);
		rdc(IDX_ACTIVATE, 8'h00);
		rdc(IDX_BASE_HI, 8'h00);
		sel(4'h7);
		rdc(IDX_IRQ_SEC, 8'h00);
		endt("reset");
		sel(4'h3);
		wr(IDX_ACTIVATE, 8'h01);
		rdc(IDX_ACTIVATE, 8'h01);
		`CHK(power_ctl, 12'h008);
		`CHK(unit_cfg[3].on, 1'b1);
		wr(IDX_ACTIVATE, 8'h00);
		`CHK(power_ctl, 12'h000);
		sel(4'h4);
		power_ctl_set = 12'h010;
		@(negedge sys_clk);
		power_ctl_set = '0;
		rdc(IDX_ACTIVATE, 8'h01);
		power_ctl_clr = 12'h010;
		@(negedge sys_clk);
		power_ctl_clr = '0;
		rdc(IDX_ACTIVATE, 8'h00);
		endt("activation");
		sel(4'h3);
		wr(IDX_BASE_HI, 8'hAB);
		wr(IDX_BASE_LO, 8'hCD);
		rdc(IDX_BASE_HI, 8'hAB);
		rdc(IDX_BASE_LO, 8'hCD);
		`CHK(unit_cfg[3].base, 16'hABCD);
		wr(IDX_BASE2_HI, 8'h11);
		rdc(IDX_BASE2_HI, 8'h00);
		sel(4'h4);
		wr(IDX_BASE2_HI, 8'h12);
		wr(IDX_BASE2_LO, 8'h34);
		rdc(IDX_BASE2_LO, 8'h34);
		`CHK(unit_cfg[4].base2, 16'h1234);
		`CHK(unit_cfg[3].base, 16'hABCD);
		sel(4'h1);
		wr(IDX_BASE_HI, 8'h55);
		rdc(IDX_BASE_HI, 8'h00);
		endt("base");
		for (int u = 0; u < UNIT_COUNT; u++) begin
			sel(4'(u));
			wr(IDX_IRQ_PRI, 8'(u + 16));
			rdc(IDX_IRQ_PRI, 8'(u + 16));
		end
		sel(4'h7);
		wr(IDX_IRQ_SEC, 8'h5A);
		rdc(IDX_IRQ_SEC, 8'h5A);
		`CHK(unit_cfg[7].irq_sec, 8'h5A);
		sel(4'h0);
		wr(IDX_IRQ_SEC, 8'h5A);
		rdc(IDX_IRQ_SEC, 8'h00);
		`CHK(unit_cfg[0].irq_sec, 8'h00);
		wr(IDX_DMA_SEL, 8'h03);
		rdc(IDX_DMA_SEL, 8'h03);
		sel(4'h4);
		wr(IDX_DMA_SEL, 8'h03);
		rdc(IDX_DMA_SEL, 8'h00);
		endt("select");
		sel(4'h3);
		for (int i = 0; i < 16; i++) begin
			wr(RSV[i], 8'hFF);
			rdc(RSV[i], 8'h00);
		end
		rdc(IDX_IRQ_PRI, 8'h13);
		config_state = 1'b0;
		wr(IDX_BASE_HI, 8'h77);
		config_state = 1'b1;
		rdc(IDX_BASE_HI, 8'hAB);
		endt("reserved");
		soft_reset = 1'b1;
		@(negedge sys_clk);
		soft_reset = 1'b0;
		sel(4'h0);
		rdc(IDX_IRQ_PRI, 8'h06);
		sel(4'h3);
		rdc(IDX_BASE_HI, 8'h00);
		wr(IDX_BASE_LO, 8'h44);
		rst_b = 1'b0;
		@(negedge sys_clk);
		rst_b = 1'b1;
		`CHK(unit_cfg[3].base, 16'h0000);
		`CHK(unit_cfg[0].irq_pri, 8'h06);
		endt("resets");
		close_out();
	end
endmodule
